// ===== core/mph_cfg.svh
// constants of the nibble-interface phy block: slot counts, sqe length
// assumes inclusion by the phy core only; the types live in mph_pkg
`ifndef MPH_CFG_SVH
`define MPH_CFG_SVH

// ----------------------------------------------------------------
// line slots per nibble, last slot index and clock fall slot
// ----------------------------------------------------------------
`define MPH_LAST_100 3'h3
`define MPH_FALL_100 3'h2
`define MPH_LAST_10 3'h7
`define MPH_FALL_10 3'h4
// parked slot while disabled: at or past every last slot, so the next is slot 0
`define MPH_PHASE_PARK 3'h7

// ----------------------------------------------------------------
// sqe test length in nibble periods, receive buffer shape
// ----------------------------------------------------------------
`define MPH_SQE_NIBBLES 4'h4
`define MPH_BUF_DEPTH 2
`define MPH_BUF_WIDTH 5

`endif

// ===== core/mph_pkg.sv
// types shared by the nibble-interface phy block
// assumes nothing of its surroundings
package mph_pkg;

  // ----------------------------------------------------------------
  // transmit sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MPH_TX_IDLE = 2'b00,
    MPH_TX_SEND = 2'b01,
    MPH_TX_SQE = 2'b10
  } mph_tx_state_e;

  typedef logic [3:0] mph_nibble_t;

endpackage

// ===== core/mph_mii_phy.sv
// phy side of the nibble interface: clocks, serialiser, crs and col
// assumes the mac drives txd on our transmit clock; front end pins async
`timescale 1ns/1ps
`include "mph_cfg.svh"

module mph_mii_phy
  import mph_pkg::*;
#(
  parameter int BUF_DEPTH = `MPH_BUF_DEPTH,
  parameter int BUF_WIDTH = `MPH_BUF_WIDTH,
  parameter logic [3:0] SQE_NIBBLES = `MPH_SQE_NIBBLES
)
(
  // system clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // mode, system domain
  input wire logic SPEED_100_I,
  input wire logic FULL_DUPLEX_I,
  // status, system domain
  output logic READY_O,
  // link clock
  input wire logic LINE_CLK_I,
  // nibble transmit
  output logic TX_CLK_O,
  input wire logic [3:0] TXD_I,
  input wire logic TX_EN_I,
  input wire logic TX_ER_I,
  // nibble receive and status
  output logic RX_CLK_O,
  output logic [3:0] RXD_O,
  output logic RX_DV_O,
  output logic RX_ER_O,
  output logic CRS_O,
  output logic COL_O,
  output logic MII_OE_O,
  // twisted pair
  output logic LINE_TX_POS_O,
  output logic LINE_TX_NEG_O,
  output logic LINE_TX_OE_O,
  input wire logic LINE_RX_I,
  input wire logic LINE_RX_ACT_I
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W = $clog2(BUF_DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);

  // ----------------------------------------------------------------
  // slot decode shared by serialiser and deserialiser
  // ----------------------------------------------------------------
  function automatic logic [1:0] slot_index(input logic fast,
                                            input logic [2:0] ph);
    if (fast)
    begin
      slot_index = ph[1:0];
    end
    else
    begin
      slot_index = ph[2:1];
    end
  endfunction

  // ----------------------------------------------------------------
  // line domain reset, async assert and sync release
  // ----------------------------------------------------------------
  logic line_rst_meta_reg;
  logic line_rst_reg;
  logic enable_reg;

  always_ff @(posedge LINE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      line_rst_meta_reg <= 1'b1;
      line_rst_reg <= 1'b1;
    end
    else
    begin
      line_rst_meta_reg <= 1'b0;
      line_rst_reg <= line_rst_meta_reg;
    end
  end

  // isolation gate for every pin we drive except rxd, rx_dv and rx_er
  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      enable_reg <= 1'b0;
    end
    else
    begin
      enable_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // synchronisers into the line domain
  // ----------------------------------------------------------------
  logic [3:0] sync_meta_reg;
  logic [3:0] sync_reg;

  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      sync_meta_reg <= 4'h0;
      sync_reg <= 4'h0;
    end
    else
    begin
      sync_meta_reg <= {LINE_RX_ACT_I, LINE_RX_I, FULL_DUPLEX_I, SPEED_100_I};
      sync_reg <= sync_meta_reg;
    end
  end

  logic speed100;
  logic full_dup;
  logic line_rx;
  logic line_act;
  assign speed100 = sync_reg[0];
  assign full_dup = sync_reg[1];
  assign line_rx = sync_reg[2];
  assign line_act = sync_reg[3];

  // ----------------------------------------------------------------
  // slot counter and nibble clocks
  // ----------------------------------------------------------------
  // a speed change mid nibble gives one short nibble period
  logic [2:0] phase_reg;
  logic [2:0] phase_next;
  logic [2:0] last_phase;
  logic [2:0] fall_phase;
  logic is_last;
  logic fall_edge;
  logic nib_clk_next;

  assign last_phase = speed100 ? `MPH_LAST_100 : `MPH_LAST_10;
  assign fall_phase = speed100 ? `MPH_FALL_100 : `MPH_FALL_10;
  assign is_last = (phase_reg >= last_phase);
  assign phase_next = is_last ? 3'h0 : phase_reg + 3'h1;
  assign fall_edge = (phase_next == fall_phase);
  assign nib_clk_next = enable_reg & (phase_next < fall_phase);

  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      phase_reg <= 3'h0;
    end
    else if (!enable_reg)
    begin
      // speed is not synced yet; parking avoids a short first clock
      phase_reg <= `MPH_PHASE_PARK;
    end
    else
    begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      TX_CLK_O <= 1'b0;
      RX_CLK_O <= 1'b0;
    end
    else
    begin
      TX_CLK_O <= nib_clk_next;
      RX_CLK_O <= nib_clk_next;
    end
  end

  // ----------------------------------------------------------------
  // transmit capture, mac side already on our clock
  // ----------------------------------------------------------------
  mph_nibble_t tx_hold_reg;
  logic tx_hold_en_reg;
  logic tx_hold_er_reg;
  mph_nibble_t tx_data_reg;
  logic tx_data_er_reg;

  // sampled at the falling edge, half a period after the mac launched
  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      tx_hold_reg <= 4'h0;
      tx_hold_en_reg <= 1'b0;
      tx_hold_er_reg <= 1'b0;
    end
    else if (fall_edge)
    begin
      tx_hold_reg <= TXD_I;
      tx_hold_en_reg <= TX_EN_I;
      tx_hold_er_reg <= TX_ER_I;
    end
  end

  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      tx_data_reg <= 4'h0;
      tx_data_er_reg <= 1'b0;
    end
    else if (is_last)
    begin
      tx_data_reg <= tx_hold_reg;
      tx_data_er_reg <= tx_hold_er_reg;
    end
  end

  // ----------------------------------------------------------------
  // transmit sequencer with sqe test
  // ----------------------------------------------------------------
  mph_tx_state_e state_reg;
  mph_tx_state_e state_next;
  logic [3:0] sqe_cnt_reg;
  logic loop10;
  logic tx_on;

  assign loop10 = !speed100 && !full_dup;
  assign tx_on = (state_reg == MPH_TX_SEND);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      MPH_TX_IDLE:
      begin
        if (is_last && tx_hold_en_reg)
        begin
          state_next = MPH_TX_SEND;
        end
      end
      MPH_TX_SEND:
      begin
        if (is_last && !tx_hold_en_reg)
        begin
          state_next = loop10 ? MPH_TX_SQE : MPH_TX_IDLE;
        end
      end
      MPH_TX_SQE:
      begin
        if (is_last && tx_hold_en_reg)
        begin
          state_next = MPH_TX_SEND;
        end
        else if (!loop10 || (is_last && sqe_cnt_reg <= 4'h1))
        begin
          state_next = MPH_TX_IDLE;
        end
      end
      default:
      begin
        state_next = MPH_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      state_reg <= MPH_TX_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      sqe_cnt_reg <= 4'h0;
    end
    else if (state_reg != MPH_TX_SQE)
    begin
      sqe_cnt_reg <= SQE_NIBBLES;
    end
    else if (is_last)
    begin
      sqe_cnt_reg <= sqe_cnt_reg - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // line serialiser, manchester at 10 Mb/s
  // ----------------------------------------------------------------
  logic tx_bit;
  logic line_val;

  assign tx_bit = tx_data_reg[slot_index(speed100, phase_reg)];
  // first half carries the complement, second half the bit
  assign line_val = speed100 ? tx_bit
                             : (phase_reg[0] ? tx_bit : ~tx_bit);

  // error nibble marks both legs high; line coding lies outside
  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      LINE_TX_POS_O <= 1'b0;
      LINE_TX_NEG_O <= 1'b0;
      LINE_TX_OE_O <= 1'b0;
    end
    else
    begin
      LINE_TX_POS_O <= enable_reg & tx_on & (line_val | tx_data_er_reg);
      LINE_TX_NEG_O <= enable_reg & tx_on & (~line_val | tx_data_er_reg);
      LINE_TX_OE_O <= enable_reg;
    end
  end

  // ----------------------------------------------------------------
  // receive deserialiser with loopback
  // ----------------------------------------------------------------
  logic loop_now;
  logic rx_src;
  logic rx_act_src;
  logic rx_first_reg;
  logic rx_bad_reg;
  logic rx_act_reg;
  mph_nibble_t rx_nib_reg;

  assign loop_now = loop10 && tx_on;
  assign rx_src = loop_now ? line_val : line_rx;
  assign rx_act_src = loop_now | line_act;

  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      rx_first_reg <= 1'b0;
      rx_nib_reg <= 4'h0;
    end
    else if (speed100 || phase_reg[0])
    begin
      rx_nib_reg[slot_index(speed100, phase_reg)] <= rx_src;
    end
    else
    begin
      rx_first_reg <= rx_src;
    end
  end

  // equal halves are a manchester violation
  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      rx_bad_reg <= 1'b0;
      rx_act_reg <= 1'b0;
    end
    else if (phase_reg == 3'h0)
    begin
      rx_bad_reg <= 1'b0;
      rx_act_reg <= rx_act_src;
    end
    else
    begin
      rx_bad_reg <= rx_bad_reg | (!speed100 && phase_reg[0] &&
                    rx_act_src && (rx_src == rx_first_reg));
      rx_act_reg <= rx_act_reg | rx_act_src;
    end
  end

  // ----------------------------------------------------------------
  // pending nibble and two-entry receive buffer
  // ----------------------------------------------------------------
  // the line cannot be stalled: an unpushed nibble is overwritten and
  // its successor carries the error flag
  logic [BUF_WIDTH-1:0] pend_data_reg;
  logic pend_valid_reg;
  logic [BUF_WIDTH-1:0] buf_mem_reg [BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic in_ready;
  logic push;
  logic out_valid;
  logic pop;

  assign in_ready = (cnt_reg != CNT_FULL);
  assign push = pend_valid_reg & in_ready;
  assign out_valid = (cnt_reg != '0);
  assign pop = out_valid & fall_edge;

  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      pend_data_reg <= '0;
      pend_valid_reg <= 1'b0;
    end
    else if (phase_reg == 3'h0)
    begin
      pend_data_reg <= {rx_bad_reg | (pend_valid_reg & ~push), rx_nib_reg};
      pend_valid_reg <= rx_act_reg;
    end
    else if (push)
    begin
      pend_valid_reg <= 1'b0;
    end
  end

  generate
    for (genvar i = 0; i < BUF_DEPTH; i++)
    begin : g_buf
      always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
      begin
        if (line_rst_reg)
        begin
          buf_mem_reg[i] <= '0;
        end
        else if (push && wr_ptr_reg == PTR_W'(i))
        begin
          buf_mem_reg[i] <= pend_data_reg;
        end
      end
    end
  endgenerate

  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive outputs, changed at the falling clock edge
  // ----------------------------------------------------------------
  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      RXD_O <= 4'h0;
      RX_DV_O <= 1'b0;
      RX_ER_O <= 1'b0;
    end
    else if (fall_edge)
    begin
      RXD_O <= pop ? buf_mem_reg[rd_ptr_reg][3:0] : 4'h0;
      RX_DV_O <= pop;
      RX_ER_O <= pop & buf_mem_reg[rd_ptr_reg][4];
    end
  end

  // ----------------------------------------------------------------
  // carrier sense and collision
  // ----------------------------------------------------------------
  always_ff @(posedge LINE_CLK_I or posedge line_rst_reg)
  begin
    if (line_rst_reg)
    begin
      CRS_O <= 1'b0;
      COL_O <= 1'b0;
      MII_OE_O <= 1'b0;
    end
    else
    begin
      if (full_dup)
      begin
        CRS_O <= enable_reg & line_act;
        COL_O <= 1'b0;
      end
      else
      begin
        CRS_O <= enable_reg & (tx_on | line_act);
        COL_O <= enable_reg & ((tx_on & line_act) |
                 (state_reg == MPH_TX_SQE));
      end
      MII_OE_O <= enable_reg;
    end
  end

  // ----------------------------------------------------------------
  // ready status back into the system domain
  // ----------------------------------------------------------------
  logic rdy_meta_reg;

  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rdy_meta_reg <= 1'b0;
      READY_O <= 1'b0;
    end
    else
    begin
      rdy_meta_reg <= enable_reg;
      READY_O <= rdy_meta_reg;
    end
  end

endmodule

// ===== dv/mph_mii_phy_assertions.sv
// checker of the nibble-interface phy: clocks, isolation, crs and col
// assumes binding to mph_mii_phy; mode pins change only under reset
`timescale 1ns/1ps

module mph_mii_phy_assertions
(
  // clock and reset
  input wire logic LINE_CLK_I,
  input wire logic RST_I,
  // mode
  input wire logic SPEED_100_I,
  input wire logic FULL_DUPLEX_I,
  // nibble interface
  input wire logic TX_CLK_O,
  input wire logic TX_EN_I,
  input wire logic RX_CLK_O,
  input wire logic [3:0] RXD_O,
  input wire logic RX_DV_O,
  input wire logic RX_ER_O,
  input wire logic CRS_O,
  input wire logic COL_O,
  input wire logic MII_OE_O,
  // line
  input wire logic LINE_TX_POS_O,
  input wire logic LINE_TX_NEG_O,
  input wire logic LINE_TX_OE_O,
  input wire logic LINE_RX_ACT_I
);

  default clocking cb @(posedge LINE_CLK_I);
  endclocking
  default disable iff (RST_I);

  // ----------------
  // sequences
  // ----------------
  sequence per_100;
    TX_CLK_O[*2] ##1 !TX_CLK_O[*2] ##1 TX_CLK_O;
  endsequence
  sequence per_10;
    TX_CLK_O[*4] ##1 !TX_CLK_O[*4] ##1 TX_CLK_O;
  endsequence
  // six samples clear the pin sync plus the output register
  sequence act_steady;
    (FULL_DUPLEX_I && MII_OE_O && $stable(LINE_RX_ACT_I))[*6];
  endsequence
  sequence hd_tx;
    (!FULL_DUPLEX_I && TX_EN_I)[*8];
  endsequence
  sequence hd_overlap;
    (!FULL_DUPLEX_I && TX_EN_I && LINE_RX_ACT_I)[*8];
  endsequence

  // ----------------
  // assertions
  // ----------------
  reset_iso_a: assert property (disable iff (1'b0)
    RST_I |-> !(MII_OE_O | LINE_TX_OE_O | LINE_TX_POS_O | LINE_TX_NEG_O))
    else $error("interface not isolated in reset");
  oe_pair_a: assert property (
    MII_OE_O == LINE_TX_OE_O) else $error("enables disagree");
  oe_hold_a: assert property (
    MII_OE_O |=> MII_OE_O) else $error("interface dropped");
  clk_same_a: assert property (
    TX_CLK_O == RX_CLK_O) else $error("nibble clocks differ");
  clk_fast_a: assert property (
    SPEED_100_I && $rose(TX_CLK_O) |-> per_100)
    else $error("bad fast nibble clock");
  clk_slow_a: assert property (
    !SPEED_100_I && $rose(TX_CLK_O) |-> per_10)
    else $error("bad slow nibble clock");
  fd_crs_a: assert property (
    act_steady |-> CRS_O == LINE_RX_ACT_I)
    else $error("full duplex carrier wrong");
  fd_col_a: assert property (
    FULL_DUPLEX_I |-> !COL_O) else $error("full duplex collision");
  hd_crs_a: assert property (
    hd_tx |-> ##2 CRS_O) else $error("no carrier while sending");
  hd_col_a: assert property (
    hd_overlap |-> ##2 COL_O) else $error("collision missed");
  sqe_test_a: assert property (
    !SPEED_100_I && !FULL_DUPLEX_I && !LINE_RX_ACT_I && $fell(TX_EN_I)
    |-> ##[1:40] COL_O) else $error("no sqe after frame");
  rx_edge_a: assert property (
    !$stable({RXD_O, RX_DV_O, RX_ER_O}) |-> $fell(RX_CLK_O))
    else $error("receive moved off clock fall");

endmodule

bind mph_mii_phy mph_mii_phy_assertions u_mph_mii_phy_assertions (
  .LINE_CLK_I, .RST_I, .SPEED_100_I, .FULL_DUPLEX_I, .TX_CLK_O, .TX_EN_I,
  .RX_CLK_O, .RXD_O, .RX_DV_O, .RX_ER_O, .CRS_O, .COL_O, .MII_OE_O,
  .LINE_TX_POS_O, .LINE_TX_NEG_O, .LINE_TX_OE_O, .LINE_RX_ACT_I);

// ===== dv/mph_mac_model.sv
// behavioural mac: sends nibble frames on the phy's transmit clock
// assumes the bench calls send only once the phy reports ready
`timescale 1ns/1ps

module mph_mac_model
(
  // clock from the phy
  input wire logic tx_clk_i,
  // nibble transmit
  output logic [3:0] txd_o,
  output logic tx_en_o,
  output logic tx_er_o
);

  initial
  begin
    txd_o = 4'h0;
    tx_en_o = 1'b0;
    tx_er_o = 1'b0;
  end

  // one nibble a period, launched just after the rising edge
  task automatic send(input logic [3:0] first, input int len,
    input int err_at);
    for (int k = 0; k < len; k++)
    begin
      @(posedge tx_clk_i);
      #1;
      txd_o = first + 4'(k);
      tx_en_o = 1'b1;
      tx_er_o = (k == err_at);
    end
    @(posedge tx_clk_i);
    #1;
    tx_en_o = 1'b0;
    tx_er_o = 1'b0;
    // idle nibble is junk, never a copy of the last data
    txd_o = ~txd_o;
  endtask

endmodule

// ===== dv/test_mii_data_duplex_phy_side.sv
// bench of the nibble-interface phy: mac model, line stimulus, checks
// assumes mph_mii_phy with default parameters and its bound checker
`timescale 1ns/1ps

module test_mii_data_duplex_phy_side;

  logic sys_clk = 1'b0;
  logic line_clk = 1'b0;
  logic rst = 1'b0;
  logic speed_100 = 1'b1;
  logic full_duplex = 1'b1;
  logic line_rx = 1'b0;
  logic line_rx_act = 1'b0;
  logic ready, tx_clk, rx_clk, rx_dv, rx_er, crs, col, mii_oe;
  logic pos, neg, line_oe, tx_en, tx_er;
  logic [3:0] txd, rxd;
  int n_errors = 0;
  int checks_done = 0;

  always #2 sys_clk = ~sys_clk;
  // link clock offset so its edges never meet the system clock
  initial
  begin
    #1.3;
    forever #16 line_clk = ~line_clk;
  end

  mph_mii_phy u_mph_mii_phy (.SYS_CLK_I(sys_clk), .RST_I(rst),
    .SPEED_100_I(speed_100), .FULL_DUPLEX_I(full_duplex), .READY_O(ready),
    .LINE_CLK_I(line_clk), .TX_CLK_O(tx_clk), .TXD_I(txd),
    .TX_EN_I(tx_en), .TX_ER_I(tx_er), .RX_CLK_O(rx_clk), .RXD_O(rxd),
    .RX_DV_O(rx_dv), .RX_ER_O(rx_er), .CRS_O(crs), .COL_O(col),
    .MII_OE_O(mii_oe), .LINE_TX_POS_O(pos), .LINE_TX_NEG_O(neg),
    .LINE_TX_OE_O(line_oe), .LINE_RX_I(line_rx),
    .LINE_RX_ACT_I(line_rx_act));

  mph_mac_model u_mph_mac_model (.tx_clk_i(tx_clk), .txd_o(txd),
    .tx_en_o(tx_en), .tx_er_o(tx_er));

  // ----------------
  // helpers
  // ----------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic lc(input int n);
    repeat (n) @(posedge line_clk);
    #1;
  endtask

  task automatic do_reset(input logic spd, input logic fd);
    int i;
    rst = 1'b1;
    speed_100 = spd;
    full_duplex = fd;
    lc(2);
    chk({mii_oe, line_oe, pos, neg, crs, col, rx_dv, ready}, 8'h00);
    rst = 1'b0;
    for (i = 0; i < 20 && ready !== 1'b1; i++)
      lc(1);
    chk({5'h0, mii_oe, line_oe, ready}, 8'h07);
  endtask

  // ----------------
  // scenarios
  // ----------------
  task automatic tx_line(input logic spd);
    int i, s, p;
    logic b;
    logic [3:0] a = 4'h6;
    p = spd ? 4 : 8;
    do_reset(spd, 1'b1);
    fork
      u_mph_mac_model.send(a, 2, 1);
      begin
        for (i = 0; i < 200 && !(pos | neg); i++)
          @(negedge line_clk);
        for (s = 0; s < 2 * p; s++)
        begin
          b = a[spd ? s : s / 2] ^ (!spd && !s[0]);
          chk({6'h0, pos, neg}, (s >= p) ? 8'h03 : {6'h0, b, !b});
          @(negedge line_clk);
        end
      end
    join
  endtask

  task automatic crs_col(input logic fd);
    do_reset(1'b1, fd);
    fork
      u_mph_mac_model.send(4'h1, 12, -1);
      begin
        lc(12);
        chk({7'h0, crs}, {7'h0, !fd});
        line_rx_act = 1'b1;
        lc(10);
        chk({6'h0, crs, col}, {6'h0, 1'b1, !fd});
        line_rx_act = 1'b0;
      end
    join
    lc(10);
    chk({6'h0, crs, col}, 8'h00);
  endtask

  task automatic rx_data(input logic spd, input logic alt);
    int i, seen;
    logic er;
    logic [3:0] got;
    seen = 0;
    er = 1'b0;
    got = 4'h0;
    do_reset(spd, 1'b1);
    @(posedge tx_clk);
    #1;
    line_rx_act = 1'b1;
    for (i = 0; i < 64; i++)
    begin
      line_rx = alt ? i[0] : 1'b1;
      @(negedge line_clk);
      seen = seen + (rx_dv === 1'b1);
      if (seen == 20)
      begin
        got = rxd;
        er = rx_er;
      end
      lc(1);
    end
    line_rx_act = 1'b0;
    line_rx = ~line_rx;
    chk({7'h0, er}, {7'h0, !spd && !alt});
    if (spd || alt)
      chk({7'h0, got === 4'hF || (alt && got === 4'h0)}, 8'h01);
    lc(30);
    chk({7'h0, rx_dv}, 8'h00);
  endtask

  task automatic loop_sqe(input logic fd);
    int i;
    logic dv_seen, col_seen;
    dv_seen = 1'b0;
    col_seen = 1'b0;
    do_reset(1'b0, fd);
    fork
      u_mph_mac_model.send(4'h3, 3, -1);
      for (i = 0; i < 120; i++)
      begin
        @(negedge line_clk);
        dv_seen = dv_seen | (rx_dv === 1'b1 && rxd === 4'h3);
        col_seen = col_seen | (col === 1'b1);
      end
    join
    chk({6'h0, dv_seen, col_seen}, {6'h0, !fd, !fd});
  endtask

  // ----------------
  // main sequence and watchdog
  // ----------------
  initial
  begin
    // a real rising edge on reset, so the async clear is seen
    #1;
    tx_line(1'b1);
    tx_line(1'b0);
    crs_col(1'b0);
    crs_col(1'b1);
    rx_data(1'b1, 1'b0);
    rx_data(1'b0, 1'b1);
    rx_data(1'b0, 1'b0);
    loop_sqe(1'b0);
    loop_sqe(1'b1);
    summarize();
  end

  // the scenarios need about 25 us; eight times that means a hang
  initial
  begin
    #200000;
    n_errors++;
    summarize();
  end

endmodule
